// ===== rtl/dmac_pkg.sv
/*
 dmac_pkg: constants and types shared by the four-channel cycle-stealing
 transfer controller and its per-channel request latch.
 Assumes a 32-bit AHB-Lite register bus and a 24-bit, 16-bit-data system bus.
*/
package dmac_pkg;
   // structure
   localparam int DMAC_CHANNELS = 4;
   localparam int ADDR_W = 24;
   localparam int CNT_W = 16;
   localparam int DATA_W = 16;
   localparam int PERIPH_N = 22;
   localparam int CFG_W = 13;
   localparam int SEL_W = 5;

   // register windows: channels two and three sit in the second bank
   localparam logic [31:0] CH_BASE [DMAC_CHANNELS] = '{
      32'h0000_0000, 32'h0000_0020, 32'h0000_0100, 32'h0000_0120};

   // register index inside a channel window (byte offset = index * 4)
   localparam logic [2:0] IDX_MODE = 3'h0;
   localparam logic [2:0] IDX_CFG = 3'h1;
   localparam logic [2:0] IDX_SRC = 3'h2;
   localparam logic [2:0] IDX_DST = 3'h3;
   localparam logic [2:0] IDX_COUNT = 3'h4;
   localparam logic [2:0] IDX_RELOAD = 3'h5;
   localparam logic [2:0] IDX_SWREQ = 3'h6;

   // transfer mode select values
   localparam logic [1:0] MODE_OFF = 2'h0;
   localparam logic [1:0] MODE_SINGLE = 2'h1;
   localparam logic [1:0] MODE_REPEAT = 2'h3;

   // configuration field positions
   localparam int CFG_WORD_BIT = 0;
   localparam int CFG_SRC_INC_BIT = 1;
   localparam int CFG_SRC8_BIT = 2;
   localparam int CFG_DST8_BIT = 3;
   localparam int CFG_SRC_WAIT_BIT = 4;
   localparam int CFG_DST_WAIT_BIT = 5;
   localparam int CFG_SEL_LSB = 8;

   // mode register read-back status positions
   localparam int STAT_ACTIVE_BIT = 16;
   localparam int STAT_REQ_BIT = 17;

   // request source select codes
   localparam logic [SEL_W-1:0] SEL_SOFT = 5'h00;
   localparam logic [SEL_W-1:0] SEL_EXT_FALL = 5'h01;
   localparam logic [SEL_W-1:0] SEL_EXT_BOTH = 5'h02;
   localparam logic [SEL_W-1:0] SEL_PERIPH0 = 5'h03;

   // reset values
   localparam logic [CFG_W-1:0] RST_CFG = 13'h0000;
   localparam logic [ADDR_W-1:0] RST_ADDR = 24'h00_0000;
   localparam logic [CNT_W-1:0] RST_CNT = 16'h0000;

   // timing, in bus clock cycles
   localparam logic [1:0] ACC_BASE_CYC = 2'h1;
   localparam logic [1:0] WAIT_EXTRA_CYC = 2'h1;

   typedef enum logic [2:0] {
      DMAC_IDLE, DMAC_ARB, DMAC_READ, DMAC_WRITE, DMAC_GAP, DMAC_HANDBACK
   } dmac_state_t;
endpackage

// ===== rtl/dmac_req.sv
/*
 dmac_req: request latch of one channel, with source selection and edge
 detection of the channel's external request pin.
 Assumes peripheral request inputs are one-cycle pulses, synchronous to the
 clock, and the external pin is already synchronous.
*/
`timescale 1ns/10ps
module dmac_req (
   // clock and reset
   input wire logic mclk_in,
   input wire logic reset_n_in,
   // trigger sources
   input wire logic [dmac_pkg::SEL_W-1:0] sel_in,
   input wire logic ext_request_pin_in,
   input wire logic [dmac_pkg::PERIPH_N-1:0] periph_irq_in,
   input wire logic sw_set_in,
   // channel control
   input wire logic start_clr_in,
   input wire logic enabled_in,
   // latched request
   output logic req_out
);
   import dmac_pkg::*;

   logic pin_prev_q;
   logic req_q;
   logic [SEL_W-1:0] pidx;
   wire pin_fall;
   wire pin_both;
   wire periph_hit;
   wire trig;

   assign pidx = sel_in - SEL_PERIPH0;
   assign pin_fall = pin_prev_q & ~ext_request_pin_in;
   assign pin_both = pin_prev_q ^ ext_request_pin_in;
   // out-of-range codes select no peripheral or pin; a software request still sets the latch
   assign periph_hit = (sel_in >= SEL_PERIPH0) &&
      (pidx < SEL_W'(PERIPH_N)) ? periph_irq_in[pidx] : 1'b0;
   assign trig = sw_set_in | periph_hit |
      ((sel_in == SEL_EXT_FALL) & pin_fall) |
      ((sel_in == SEL_EXT_BOTH) & pin_both);

   always_ff @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         pin_prev_q <= 1'b1;
         req_q <= 1'b0;
      end else begin
         pin_prev_q <= ext_request_pin_in;
         if (!enabled_in) begin
            req_q <= 1'b0;
         end else if (trig) begin
            // a fresh trigger beats the start clear; extra ones merge
            req_q <= 1'b1;
         end else if (start_clr_in) begin
            req_q <= 1'b0;
         end
      end
   end

   assign req_out = req_q;
endmodule

// ===== rtl/dmac_top.sv
/*
 dmac_top: four-channel cycle-stealing transfer controller with an AHB-Lite
 register slave and a simple request/grant master port on the system bus.
 Assumes the bus arbiter grants this block ahead of the processor, memory
 answers a read in the last cycle of each access, and byte data always
 travels on the low lane of the memory data bus.
*/
// The register offsets and register access over AHB-Lite were chosen for this implementation.
`timescale 1ns/10ps
module dmac_top (
   // clock and reset
   input wire logic mclk_in,
   input wire logic reset_n_in,
   // AHB-Lite register slave
   input wire logic hsel_in,
   input wire logic [31:0] haddr_in,
   input wire logic [1:0] htrans_in,
   input wire logic hwrite_in,
   input wire logic [2:0] hsize_in,
   input wire logic [31:0] hwdata_in,
   input wire logic hready_in,
   output logic [31:0] hrdata_out,
   output logic hreadyout_out,
   output logic hresp_out,
   // request sources
   input wire logic [dmac_pkg::DMAC_CHANNELS-1:0] ext_request_pin_in,
   input wire logic [dmac_pkg::PERIPH_N-1:0] periph_irq_in,
   // bus arbitration with the processor
   output logic bus_req_out,
   input wire logic bus_grant_in,
   input wire logic cpu_bus_req_in,
   input wire logic cpu_cycle_done_in,
   // system bus master
   output logic [dmac_pkg::ADDR_W-1:0] mem_addr_out,
   output logic mem_rd_out,
   output logic mem_wr_out,
   output logic mem_word_out,
   output logic [dmac_pkg::DATA_W-1:0] mem_wdata_out,
   input wire logic [dmac_pkg::DATA_W-1:0] mem_rdata_in,
   // status
   output logic [dmac_pkg::DMAC_CHANNELS-1:0] done_irq_out,
   output logic [dmac_pkg::DMAC_CHANNELS-1:0] chan_active_out,
   output logic fast_irq_avail_out
);
   import dmac_pkg::*;
   // channel registers
   logic [1:0] mode_q [DMAC_CHANNELS];
   logic [CFG_W-1:0] cfg_q [DMAC_CHANNELS];
   logic [ADDR_W-1:0] src_q [DMAC_CHANNELS];
   logic [ADDR_W-1:0] dst_q [DMAC_CHANNELS];
   logic [CNT_W-1:0] cnt_q [DMAC_CHANNELS];
   logic [CNT_W-1:0] rld_q [DMAC_CHANNELS];
   logic [DMAC_CHANNELS-1:0] req_w;
   logic [DMAC_CHANNELS-1:0] en_w;
   // bus slave state
   logic wr_pend_q;
   logic [1:0] wr_ch_q;
   logic [2:0] wr_idx_q;
   // engine state
   dmac_state_t state_q;
   logic [1:0] ch_q;
   logic beat_q;
   logic [1:0] cyc_q;
   logic [DATA_W-1:0] data_q;
   logic bus_req_q;
   logic [ADDR_W-1:0] mem_addr_q;
   logic mem_rd_q;
   logic mem_wr_q;
   logic mem_word_q;
   logic [DATA_W-1:0] mem_wdata_q;
   function automatic logic chan_enabled(input logic [1:0] m,
                                         input logic [CNT_W-1:0] c);
      return (m == MODE_REPEAT) ||
         ((m == MODE_SINGLE) && (c != RST_CNT));
   endfunction
   // returns {hit, channel, index}
   function automatic logic [5:0] reg_decode(input logic [31:0] a);
      logic [5:0] r;
      r = 6'h00;
      for (int i = 0; i < DMAC_CHANNELS; i++) begin
         if ((a[31:5] == CH_BASE[i][31:5]) && (a[1:0] == 2'h0) &&
             (a[4:2] <= IDX_SWREQ)) begin
            r = {1'b1, 2'(i), a[4:2]};
         end
      end
      return r;
   endfunction
   function automatic logic [ADDR_W-1:0] addr_step(
      input logic [ADDR_W-1:0] a, input logic word);
      // wraps inside the 16-Mbyte space
      return word ? a + 24'h00_0002 : a + 24'h00_0001;
   endfunction
   function automatic logic [1:0] acc_cycles(input logic waited);
      return waited ? ACC_BASE_CYC + WAIT_EXTRA_CYC : ACC_BASE_CYC;
   endfunction
   // AHB address phase decode
   wire ap_valid = hsel_in & htrans_in[1] & hready_in;
   wire [5:0] ap_dec = reg_decode(haddr_in);
   wire ap_hit = ap_dec[5];
   wire [1:0] ap_ch = ap_dec[4:3];
   wire [2:0] ap_idx = ap_dec[2:0];
   logic [31:0] rd_value;

   always_comb begin
      rd_value = 32'h0000_0000;
      if (ap_hit) begin
         case (ap_idx)
            IDX_MODE: begin
               rd_value[1:0] = mode_q[ap_ch];
               rd_value[STAT_ACTIVE_BIT] = en_w[ap_ch];
               rd_value[STAT_REQ_BIT] = req_w[ap_ch];
            end
            IDX_CFG: rd_value[CFG_W-1:0] = cfg_q[ap_ch];
            IDX_SRC: rd_value[ADDR_W-1:0] = src_q[ap_ch];
            IDX_DST: rd_value[ADDR_W-1:0] = dst_q[ap_ch];
            IDX_COUNT: rd_value[CNT_W-1:0] = cnt_q[ap_ch];
            IDX_RELOAD: rd_value[CNT_W-1:0] = rld_q[ap_ch];
            default: rd_value = 32'h0000_0000;
         endcase
      end
   end
   // zero-wait slave; reads sample in the address phase
   always_ff @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         hrdata_out <= 32'h0000_0000;
         hreadyout_out <= 1'b1;
         hresp_out <= 1'b0;
         wr_pend_q <= 1'b0;
         wr_ch_q <= 2'h0;
         wr_idx_q <= 3'h0;
      end else begin
         hreadyout_out <= 1'b1;
         hresp_out <= 1'b0;
         wr_pend_q <= ap_valid & hwrite_in & ap_hit;
         wr_ch_q <= ap_ch;
         wr_idx_q <= ap_idx;
         if (ap_valid && !hwrite_in) begin
            hrdata_out <= rd_value;
         end
      end
   end
   // engine decode
   logic [1:0] pick;
   logic pick_any;
   wire [CFG_W-1:0] cur_cfg = cfg_q[ch_q];
   wire cur_word = cur_cfg[CFG_WORD_BIT];
   // odd word or 8-bit side is done as two byte accesses
   wire src_split = cur_word & (cur_cfg[CFG_SRC8_BIT] | src_q[ch_q][0]);
   wire dst_split = cur_word & (cur_cfg[CFG_DST8_BIT] | dst_q[ch_q][0]);
   wire [1:0] src_cyc = acc_cycles(cur_cfg[CFG_SRC_WAIT_BIT]);
   wire [1:0] dst_cyc = acc_cycles(cur_cfg[CFG_DST_WAIT_BIT]);
   wire cyc_last = (state_q == DMAC_READ) ? (cyc_q == src_cyc - 2'h1) :
                                            (cyc_q == dst_cyc - 2'h1);
   wire unit_done = (state_q == DMAC_WRITE) && cyc_last &&
                    (beat_q == dst_split);
   wire start_w = (state_q == DMAC_ARB) && bus_grant_in && en_w[ch_q];
   wire [DATA_W-1:0] rd_merge = !src_split ?
      (cur_word ? mem_rdata_in : {8'h00, mem_rdata_in[7:0]}) :
      (beat_q ? {mem_rdata_in[7:0], data_q[7:0]} :
                {data_q[15:8], mem_rdata_in[7:0]});
   always_comb begin
      pick = 2'h0;
      pick_any = 1'b0;
      for (int i = DMAC_CHANNELS - 1; i >= 0; i--) begin
         if (req_w[i] && en_w[i]) begin
            pick = 2'(i);
            pick_any = 1'b1;
         end
      end
   end
   // per-channel request latches
   for (genvar g = 0; g < DMAC_CHANNELS; g++) begin : g_chan
      assign en_w[g] = chan_enabled(mode_q[g], cnt_q[g]);
      dmac_req u_req (
         .mclk_in(mclk_in),
         .reset_n_in(reset_n_in),
         .sel_in(cfg_q[g][CFG_SEL_LSB +: SEL_W]),
         .ext_request_pin_in(ext_request_pin_in[g]),
         .periph_irq_in(periph_irq_in),
         .sw_set_in(wr_pend_q && (wr_ch_q == 2'(g)) &&
                    (wr_idx_q == IDX_SWREQ) && hwdata_in[0]),
         .start_clr_in(start_w && (ch_q == 2'(g))),
         .enabled_in(en_w[g]),
         .req_out(req_w[g])
      );
   end
   // channel registers: a software write wins over the engine's update
   always_ff @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         for (int i = 0; i < DMAC_CHANNELS; i++) begin
            mode_q[i] <= MODE_OFF;
            cfg_q[i] <= RST_CFG;
            src_q[i] <= RST_ADDR;
            dst_q[i] <= RST_ADDR;
            cnt_q[i] <= RST_CNT;
            rld_q[i] <= RST_CNT;
         end
         done_irq_out <= '0;
      end else begin
         for (int i = 0; i < DMAC_CHANNELS; i++) begin
            done_irq_out[i] <= unit_done && (ch_q == 2'(i)) &&
                         (cnt_q[i] == 16'h0001);
            if (unit_done && (ch_q == 2'(i))) begin
               if (cfg_q[i][CFG_SRC_INC_BIT]) begin
                  src_q[i] <= addr_step(src_q[i], cfg_q[i][CFG_WORD_BIT]);
               end else begin
                  dst_q[i] <= addr_step(dst_q[i], cfg_q[i][CFG_WORD_BIT]);
               end
               if ((cnt_q[i] == 16'h0001) && (mode_q[i] == MODE_REPEAT)) begin
                  cnt_q[i] <= rld_q[i];
               end else begin
                  // zero in repeat mode wraps, giving 64K units
                  cnt_q[i] <= cnt_q[i] - 16'h0001;
               end
            end
            if (wr_pend_q && (wr_ch_q == 2'(i))) begin
               if (wr_idx_q == IDX_MODE) begin
                  mode_q[i] <= hwdata_in[1:0];
               end else if (wr_idx_q == IDX_CFG) begin
                  cfg_q[i] <= hwdata_in[CFG_W-1:0];
               end else if (wr_idx_q == IDX_SRC) begin
                  src_q[i] <= hwdata_in[ADDR_W-1:0];
               end else if (wr_idx_q == IDX_DST) begin
                  dst_q[i] <= hwdata_in[ADDR_W-1:0];
               end else if (wr_idx_q == IDX_COUNT) begin
                  cnt_q[i] <= hwdata_in[CNT_W-1:0];
               end else if (wr_idx_q == IDX_RELOAD) begin
                  rld_q[i] <= hwdata_in[CNT_W-1:0];
               end
            end
         end
      end
   end
   // transfer engine; bus_req_out changes without the grant, the memory outputs change only while it is held
   always_ff @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         state_q <= DMAC_IDLE;
         ch_q <= 2'h0;
         beat_q <= 1'b0;
         cyc_q <= 2'h0;
         data_q <= 16'h0000;
         bus_req_q <= 1'b0;
         mem_addr_q <= RST_ADDR;
         mem_rd_q <= 1'b0;
         mem_wr_q <= 1'b0;
         mem_word_q <= 1'b0;
         mem_wdata_q <= 16'h0000;
      end else begin
         case (state_q)
            DMAC_IDLE: begin
               if (pick_any) begin
                  ch_q <= pick;
                  bus_req_q <= 1'b1;
                  state_q <= DMAC_ARB;
               end
            end
            DMAC_ARB: begin
               if (!en_w[ch_q]) begin
                  bus_req_q <= 1'b0;
                  state_q <= DMAC_IDLE;
               end else if (bus_grant_in) begin
                  mem_addr_q <= src_q[ch_q];
                  mem_rd_q <= 1'b1;
                  mem_word_q <= cur_word & ~src_split;
                  beat_q <= 1'b0;
                  cyc_q <= 2'h0;
                  state_q <= DMAC_READ;
               end
            end
            DMAC_READ: begin
               if (!cyc_last) begin
                  cyc_q <= cyc_q + 2'h1;
               end else begin
                  data_q <= rd_merge;
                  cyc_q <= 2'h0;
                  if (beat_q != src_split) begin
                     beat_q <= 1'b1;
                     mem_addr_q <= src_q[ch_q] + 24'h00_0001;
                  end else begin
                     mem_rd_q <= 1'b0;
                     mem_wr_q <= 1'b1;
                     beat_q <= 1'b0;
                     mem_addr_q <= dst_q[ch_q];
                     mem_word_q <= cur_word & ~dst_split;
                     mem_wdata_q <= dst_split ? {8'h00, rd_merge[7:0]} :
                                                rd_merge;
                     state_q <= DMAC_WRITE;
                  end
               end
            end
            DMAC_WRITE: begin
               if (!cyc_last) begin
                  cyc_q <= cyc_q + 2'h1;
               end else begin
                  cyc_q <= 2'h0;
                  if (beat_q != dst_split) begin
                     beat_q <= 1'b1;
                     mem_addr_q <= dst_q[ch_q] + 24'h00_0001;
                     mem_wdata_q <= {8'h00, data_q[15:8]};
                  end else begin
                     mem_wr_q <= 1'b0;
                     bus_req_q <= 1'b0;
                     beat_q <= 1'b0;
                     state_q <= DMAC_GAP;
                  end
               end
            end
            DMAC_GAP: begin
               // wait for the arbiter to take the grant back
               if (!bus_grant_in) begin
                  state_q <= cpu_bus_req_in ? DMAC_HANDBACK : DMAC_IDLE;
               end
            end
            DMAC_HANDBACK: begin
               // a stalled processor would otherwise starve behind us
               if (cpu_cycle_done_in || !cpu_bus_req_in) begin
                  state_q <= DMAC_IDLE;
               end
            end
            default: state_q <= DMAC_IDLE;
         endcase
      end
   end

   always_ff @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         chan_active_out <= '0;
         fast_irq_avail_out <= 1'b1;
      end else begin
         chan_active_out <= en_w;
         fast_irq_avail_out <= (mode_q[2] == MODE_OFF) &&
                               (mode_q[3] == MODE_OFF);
      end
   end

   assign bus_req_out = bus_req_q;
   assign mem_addr_out = mem_addr_q;
   assign mem_rd_out = mem_rd_q;
   assign mem_wr_out = mem_wr_q;
   assign mem_word_out = mem_word_q;
   assign mem_wdata_out = mem_wdata_q;
endmodule

// ===== testbench/dmac_monitor.sv
/* dmac_monitor: port checks on dmac_top.
   assumes a far side that hands the bus back quickly */
`timescale 1ns/10ps
module dmac_monitor (
   // watched ports
   input wire logic mclk_in,
   input wire logic reset_n_in,
   input wire logic hreadyout_out,
   input wire logic hresp_out,
   input wire logic bus_req_out,
   input wire logic bus_grant_in,
   input wire logic cpu_bus_req_in,
   input wire logic cpu_cycle_done_in,
   input wire logic mem_rd_out,
   input wire logic mem_wr_out,
   input wire logic [3:0] done_irq_out,
   input wire logic [3:0] chan_active_out,
   input wire logic fast_irq_avail_out
);
   default clocking @(posedge mclk_in); endclocking
   default disable iff (!reset_n_in);
   sequence s_unit_end;
      $fell(bus_req_out) ##0 cpu_bus_req_in;
   endsequence
   property p_granted;
      mem_rd_out || mem_wr_out |-> bus_grant_in;
   endproperty
   a_granted: assert property (p_granted)
      else $error("bus driven without grant");
   property p_okay;
      hreadyout_out && !hresp_out;
   endproperty
   a_okay: assert property (p_okay)
      else $error("register bus stalled");
   property p_read_first;
      $rose(mem_wr_out) |-> $past(mem_rd_out) || $past(mem_wr_out, 2);
   endproperty
   a_read_first: assert property (p_read_first)
      else $error("write without source read");
   property p_done_pulse;
      done_irq_out != 4'h0 |=> done_irq_out == 4'h0;
   endproperty
   a_done_pulse: assert property (p_done_pulse)
      else $error("completion not a pulse");
   property p_done_cause;
      done_irq_out != 4'h0 |-> $past(mem_wr_out) || $past(mem_wr_out, 2);
   endproperty
   a_done_cause: assert property (p_done_cause)
      else $error("completion without a unit");
   property p_handback;
      s_unit_end |=> !bus_req_out throughout (##[0:8] cpu_cycle_done_in);
   endproperty
   a_handback: assert property (p_handback)
      else $error("bus not handed back");
   property p_bank;
      $rose(chan_active_out[2]) || $rose(chan_active_out[3])
         |-> !fast_irq_avail_out;
   endproperty
   a_bank: assert property (p_bank)
      else $error("fast irq left available");
   property p_release;
      $fell(bus_req_out) |-> !mem_rd_out && !mem_wr_out;
   endproperty
   a_release: assert property (p_release)
      else $error("bus released mid access");
endmodule
bind dmac_top dmac_monitor i_dmac_monitor (.*);

// ===== testbench/dmac_partner.sv
/* dmac_partner: arbiter, cpu and memory.
   assumes one engine; the cpu always wants the bus */
`timescale 1ns/10ps
module dmac_partner (
   // clock and reset
   input wire logic mclk_in,
   input wire logic reset_n_in,
   // arbitration
   input wire logic bus_req_in,
   output logic bus_grant_out,
   output logic cpu_bus_req_out,
   output logic cpu_cycle_done_out,
   // memory
   input wire logic [23:0] mem_addr_in,
   input wire logic mem_rd_in,
   input wire logic mem_wr_in,
   input wire logic mem_word_in,
   input wire logic [15:0] mem_wdata_in,
   output logic [15:0] mem_rdata_out
);
   logic [7:0] mem [256];
   logic [7:0] a, hi;
   logic [1:0] gap_q;
   logic [15:0] last_q;
   assign a = mem_addr_in[7:0];
   assign cpu_bus_req_out = 1'b1;
   // junk on unused lanes and when idle
   assign hi = mem_word_in ? mem[a + 8'h01] : ~mem[a];
   assign mem_rdata_out = mem_rd_in ? {hi, mem[a]} : ~last_q;
   initial begin
      for (int i = 0; i < 256; i++)
         mem[i] = 8'(i * 7 + 3);
   end
   always @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         bus_grant_out <= 1'b0;
         gap_q <= 2'h0;
         cpu_cycle_done_out <= 1'b0;
         last_q <= 16'h0000;
      end else begin
         cpu_cycle_done_out <= (gap_q == 2'h1);
         if (mem_wr_in && bus_grant_out)
            mem[a] <= mem_wdata_in[7:0];
         if (mem_wr_in && bus_grant_out && mem_word_in)
            mem[a + 8'h01] <= mem_wdata_in[15:8];
         if (mem_rd_in)
            last_q <= mem_rdata_out;
         if (bus_grant_out) begin
            bus_grant_out <= bus_req_in;
            if (!bus_req_in)
               gap_q <= 2'h2;
         end else if (gap_q != 2'h0)
            gap_q <= gap_q - 2'h1;
         else
            bus_grant_out <= bus_req_in;
      end
   end
endmodule

// ===== testbench/test_four_channel_cycle_steal_dma.sv
/* test_four_channel_cycle_steal_dma: bench for dmac_top.
   assumes dmac_partner and a bound dmac_monitor */
`timescale 1ns/10ps
module test_four_channel_cycle_steal_dma;
   import dmac_pkg::*;
   typedef struct {int ch; logic [12:0] cfg; logic [7:0] src, dst;} dmac_row_t;
   dmac_row_t rows [4] = '{'{0, 13'h0003, 8'h10, 8'h80},
      '{1, 13'h0000, 8'h11, 8'h90}, '{2, 13'h0025, 8'h20, 8'hA0},
      '{3, 13'h0013, 8'h31, 8'hB1}};
   logic mclk_in = 1'b0;
   logic reset_n_in = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
   logic hwrite = 1'b0, hready, hresp, bus_req, grant, cpu_req, cpu_done;
   logic [3:0] pins = 4'hF, done, active;
   logic [21:0] periph = 22'h0;
   logic rd, wr, word, fast;
   logic [23:0] maddr;
   logic [15:0] wdata, rdata;
   int num_errors = 0, checks_done = 0, cycles = 0;
   dmac_top i_dmac_top (.mclk_in, .reset_n_in, .hsel_in(1'b1),
      .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
      .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hready),
      .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp),
      .ext_request_pin_in(pins), .periph_irq_in(periph),
      .bus_req_out(bus_req), .bus_grant_in(grant), .cpu_bus_req_in(cpu_req),
      .cpu_cycle_done_in(cpu_done), .mem_addr_out(maddr), .mem_rd_out(rd),
      .mem_wr_out(wr), .mem_word_out(word), .mem_wdata_out(wdata),
      .mem_rdata_in(rdata), .done_irq_out(done), .chan_active_out(active),
      .fast_irq_avail_out(fast));
   dmac_partner i_dmac_partner (.mclk_in, .reset_n_in, .bus_req_in(bus_req),
      .bus_grant_out(grant), .cpu_bus_req_out(cpu_req),
      .cpu_cycle_done_out(cpu_done), .mem_addr_in(maddr), .mem_rd_in(rd),
      .mem_wr_in(wr), .mem_word_in(word), .mem_wdata_in(wdata),
      .mem_rdata_out(rdata));
   initial forever #10 mclk_in = ~mclk_in;
   function automatic logic [31:0] adr(input int ch, input logic [2:0] i);
      return CH_BASE[ch] + {27'h0, i, 2'b00};
   endfunction
   task automatic conclude;
      $display("errors %0d checks %0d", num_errors, checks_done);
      if (num_errors == 0 && checks_done > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, e);
      checks_done++;
      if (g !== e) begin
         $display("Error t=%0t got=%h exp=%h", $time, g, e);
         num_errors++;
      end
   endtask
   // one single transfer; entered just after a rising edge
   task automatic ahb(input logic w, input logic [31:0] a, d);
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      do @(posedge mclk_in); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge mclk_in); while (hready !== 1'b1);
      r = hrdata;
   endtask
   task automatic cfg_ch(input int ch, input logic [12:0] c,
         input logic [7:0] s, d, input logic [15:0] n, input logic [1:0] m);
      logic [31:0] v [6];
      v = '{c, s, d, n, n, m};
      for (int i = 1; i < 7; i++)
         ahb(1'b1, adr(ch, 3'(i % 6)), v[i - 1]);
   endtask
   task automatic wait_done(input logic [3:0] m, e);
      for (int k = 0; k < 200 && (done & m) == 4'h0; k++)
         @(negedge mclk_in);
      chk(done, e);
      @(posedge mclk_in);
   endtask
   always @(posedge mclk_in) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         num_errors++;
         conclude;
      end
   end
   initial begin
      int n;
      int ch;
      logic [7:0] s, d;
      repeat (4) @(posedge mclk_in);
      reset_n_in <= 1'b1;
      @(posedge mclk_in);
      chk({bus_req, fast, active}, 6'h10);
      ahb(1'b0, adr(0, IDX_MODE), 0);
      chk(r, 32'h0);
      ahb(1'b1, adr(0, IDX_SWREQ), 32'h1);
      ahb(1'b0, adr(0, IDX_MODE), 0);
      chk(r, 32'h0);
      chk(bus_req, 1'b0);
      ahb(1'b0, 32'h0000_0080, 0);
      chk(r, 32'h0);
      foreach (rows[i]) begin
         ch = rows[i].ch;
         s = rows[i].src;
         d = rows[i].dst;
         n = rows[i].cfg[0] ? 2 : 1;
         cfg_ch(ch, rows[i].cfg, s, d, 16'h1, MODE_SINGLE);
         ahb(1'b1, adr(ch, IDX_SWREQ), 32'h1);
         wait_done(4'h1 << ch, 4'h1 << ch);
         chk(fast, ch < 2);
         for (int b = 0; b < n; b++)
            chk(i_dmac_partner.mem[d + b], 8'((s + b) * 7 + 3));
         ahb(1'b0, adr(ch, IDX_SRC), 0);
         chk(r, s + (rows[i].cfg[1] ? n : 0));
         ahb(1'b0, adr(ch, IDX_DST), 0);
         chk(r, d + (rows[i].cfg[1] ? 0 : n));
         ahb(1'b0, adr(ch, IDX_MODE), 0);
         chk(r, 32'h1);
      end
      // same-cycle edges: pin 0 falls, pin 1 rises
      pins <= 4'hD;
      cfg_ch(0, {SEL_EXT_FALL, 8'h00}, 8'h40, 8'hC0, 16'h1, MODE_SINGLE);
      cfg_ch(1, {SEL_EXT_BOTH, 8'h00}, 8'h41, 8'hC1, 16'h1, MODE_SINGLE);
      pins <= 4'hE;
      wait_done(4'h3, 4'h1);
      wait_done(4'h2, 4'h2);
      cfg_ch(2, {SEL_PERIPH0 + 5'd21, 8'h00}, 8'h50, 8'hD0, 16'h2,
         MODE_REPEAT);
      for (int k = 0; k < 2; k++) begin
         periph <= 22'h20_0000;
         @(posedge mclk_in);
         periph <= 22'h0;
         r = 32'h0;
         for (int j = 0; j < 20 && k == 0 && r !== 32'h1; j++)
            ahb(1'b0, adr(2, IDX_COUNT), 0);
      end
      wait_done(4'h4, 4'h4);
      ahb(1'b0, adr(2, IDX_COUNT), 0);
      chk(r, 32'h2);
      ahb(1'b0, adr(2, IDX_MODE), 0);
      chk(r, 32'h0001_0003);
      ahb(1'b1, adr(2, IDX_MODE), 32'h0);
      ahb(1'b0, adr(2, IDX_MODE), 0);
      chk(r, 32'h0);
      chk(active, 4'h0);
      conclude;
   end
endmodule
